// file: core/sideband_consts.svh
`ifndef SIDEBAND_CONSTS_SVH
`define SIDEBAND_CONSTS_SVH
`define NUM_MEM_PORTS 6
`define NUM_DMA_CH 8
`define NUM_CORES 2
`define IRQ_VEC_W 32
`define GP_W 32
`define TRACE_EV_W 32
`define TRACE_DIV_HALF 4'h3
`define TRACE_DIV_W 4
`define WARM_ACK_TIMEOUT 12'hFFF
`define WARM_CNT_W 12
`endif

// file: core/sideband_pkg.sv
package sideband_pkg;
  typedef struct packed {
    logic cold;
    logic warm;
    logic debug;
  } reset_req_t;
  typedef struct packed {
    logic [1:0] wait_event;
    logic [1:0] wait_irq;
    logic wake_out;
  } core_status_t;
  typedef struct packed {
    logic [31:0] irq_high;
    logic [31:0] irq_low;
  } irq_pair_t;
  typedef enum logic [1:0] {
    RST_RUN,
    RST_WARM_REQ,
    RST_WARM_HOLD,
    RST_COLD
  } rst_state_t;
endpackage : sideband_pkg

// file: core/processor_fabric_sideband.sv
`timescale 1ns/1ps
`include "sideband_consts.svh"
// Behaviour
// - combined fabric reset on cold and warm resets; cold output on cold only.
// - warm reset raises a request; fabric answers with acknowledge.
// - accept cold, warm and debug reset requests from fabric.
// - eight independent DMA request channels forwarded to DMA controller.
// - wake event input acts like a send-event instruction, waking waiting cores.
// - wake event output asserts when either core executes send-event.
// - two-bit wait-for-event flags, one per core.
// - two-bit wait-for-interrupt flags, one per core.
// - 64 interrupts as low vector 0..31 and high vector 32..63.
// - fabric interrupts treated as asynchronous and synchronised before use.
// - 32 general-purpose signals each direction.
// - a rising edge on any trace event input inserts one message into the trace stream; edges in the same cycle share one message.
// - trace port drives its own clock output into the fabric.
module processor_fabric_sideband (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // memory port clocks from fabric, edge-detected into sticky per-port seen flags
  input wire logic [`NUM_MEM_PORTS-1:0] memory_port_clock,
  output logic [`NUM_MEM_PORTS-1:0] mem_port_clock_seen,
  // internal reset causes from the reset manager
  input wire logic cold_reset_cause,
  input wire logic warm_reset_cause,
  // resets to fabric
  output logic fabric_reset_out,
  output logic fabric_cold_reset_out,
  output logic warm_reset_req_out,
  input wire logic warm_reset_ack_in,
  // reset requests from fabric
  input wire sideband_pkg::reset_req_t reset_request_in,
  output sideband_pkg::reset_req_t reset_request_to_mgr,
  // dma
  input wire logic [`NUM_DMA_CH-1:0] dma_request_in,
  output logic [`NUM_DMA_CH-1:0] dma_request_to_ctrl,
  // processor events and standby
  input wire logic wake_event_in,
  input wire logic [`NUM_CORES-1:0] core_send_event,
  input wire logic [`NUM_CORES-1:0] core_in_wfe,
  input wire logic [`NUM_CORES-1:0] core_in_wfi,
  output logic [`NUM_CORES-1:0] core_wake,
  output sideband_pkg::core_status_t processor_event_bundle,
  // interrupts
  input wire sideband_pkg::irq_pair_t irq_in,
  output sideband_pkg::irq_pair_t irq_to_gic,
  // general purpose
  input wire logic [`GP_W-1:0] gp_from_fabric,
  input wire logic [`GP_W-1:0] gp_from_processor,
  output logic [`GP_W-1:0] gp_to_processor,
  output logic [`GP_W-1:0] gp_to_fabric,
  // trace
  input wire logic [`TRACE_EV_W-1:0] trace_event_inputs,
  output logic trace_msg_valid,
  output logic [`TRACE_EV_W-1:0] trace_msg_events,
  output logic trace_port_clock_out
);

  // synchroniser stages for all pin inputs
  logic [$bits(sideband_pkg::irq_pair_t)-1:0] irq_s1_q, irq_s2_q;
  logic [`NUM_DMA_CH-1:0] dma_s1_q, dma_s2_q;
  logic [$bits(sideband_pkg::reset_req_t)-1:0] rreq_s1_q, rreq_s2_q;
  logic wake_s1_q, wake_s2_q, ack_s1_q, ack_s2_q;
  logic [`GP_W-1:0] gp_s1_q, gp_s2_q;
  logic [`TRACE_EV_W-1:0] tev_s1_q, tev_s2_q, tev_prev_q;
  logic [`NUM_MEM_PORTS-1:0] mclk_s1_q, mclk_s2_q, mclk_s3_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_s1_q <= '0;
      irq_s2_q <= '0;
      dma_s1_q <= '0;
      dma_s2_q <= '0;
      rreq_s1_q <= '0;
      rreq_s2_q <= '0;
      wake_s1_q <= 1'h0;
      wake_s2_q <= 1'h0;
      ack_s1_q <= 1'h0;
      ack_s2_q <= 1'h0;
      gp_s1_q <= '0;
      gp_s2_q <= '0;
      tev_s1_q <= '0;
      tev_s2_q <= '0;
      mclk_s1_q <= '0;
      mclk_s2_q <= '0;
    end else begin
      irq_s1_q <= irq_in;
      irq_s2_q <= irq_s1_q;
      dma_s1_q <= dma_request_in;
      dma_s2_q <= dma_s1_q;
      rreq_s1_q <= reset_request_in;
      rreq_s2_q <= rreq_s1_q;
      wake_s1_q <= wake_event_in;
      wake_s2_q <= wake_s1_q;
      ack_s1_q <= warm_reset_ack_in;
      ack_s2_q <= ack_s1_q;
      gp_s1_q <= gp_from_fabric;
      gp_s2_q <= gp_s1_q;
      tev_s1_q <= trace_event_inputs;
      tev_s2_q <= tev_s1_q;
      mclk_s1_q <= memory_port_clock;
      mclk_s2_q <= mclk_s1_q;
    end
  end

  // forwarding registers
  wire [`NUM_CORES-1:0] wake_d = core_in_wfe & {`NUM_CORES{wake_s2_q}};
  wire [`TRACE_EV_W-1:0] tev_rise = tev_s2_q & ~tev_prev_q;
  wire [`NUM_MEM_PORTS-1:0] mclk_edge = mclk_s2_q ^ mclk_s3_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_to_gic <= '0;
      dma_request_to_ctrl <= '0;
      reset_request_to_mgr <= '0;
      core_wake <= '0;
      processor_event_bundle <= '0;
      gp_to_processor <= '0;
      gp_to_fabric <= '0;
      tev_prev_q <= '0;
      trace_msg_valid <= 1'h0;
      trace_msg_events <= '0;
      mclk_s3_q <= '0;
      mem_port_clock_seen <= '0;
    end else begin
      irq_to_gic <= irq_s2_q;
      dma_request_to_ctrl <= dma_s2_q;
      reset_request_to_mgr <= rreq_s2_q;
      core_wake <= wake_d;
      processor_event_bundle.wake_out <= |core_send_event;
      processor_event_bundle.wait_event <= core_in_wfe;
      processor_event_bundle.wait_irq <= core_in_wfi;
      gp_to_processor <= gp_s2_q;
      gp_to_fabric <= gp_from_processor;
      tev_prev_q <= tev_s2_q;
      trace_msg_valid <= |tev_rise;
      trace_msg_events <= tev_rise;
      mclk_s3_q <= mclk_s2_q;
      mem_port_clock_seen <= mem_port_clock_seen | mclk_edge;
    end
  end

  // trace clock divider
  logic [`TRACE_DIV_W-1:0] tdiv_q;
  wire tdiv_wrap = (tdiv_q == `TRACE_DIV_HALF);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tdiv_q <= '0;
      trace_port_clock_out <= 1'h0;
    end else begin
      tdiv_q <= tdiv_wrap ? '0 : tdiv_q + 1'h1;
      if (tdiv_wrap) begin
        trace_port_clock_out <= ~trace_port_clock_out;
      end
    end
  end

  // reset sequencer: warm reset waits for fabric acknowledge or timeout
  sideband_pkg::rst_state_t st_q, st_d;
  logic [`WARM_CNT_W-1:0] wcnt_q;
  wire wtimeout = (wcnt_q == `WARM_ACK_TIMEOUT);

  always_comb begin
    st_d = st_q;
    case (st_q)
      sideband_pkg::RST_RUN: begin
        if (cold_reset_cause) st_d = sideband_pkg::RST_COLD;
        else if (warm_reset_cause) st_d = sideband_pkg::RST_WARM_REQ;
      end
      sideband_pkg::RST_WARM_REQ: begin
        if (cold_reset_cause) st_d = sideband_pkg::RST_COLD;
        else if (ack_s2_q || wtimeout) st_d = sideband_pkg::RST_WARM_HOLD;
      end
      sideband_pkg::RST_WARM_HOLD: begin
        if (cold_reset_cause) st_d = sideband_pkg::RST_COLD;
        else if (!warm_reset_cause) st_d = sideband_pkg::RST_RUN;
      end
      sideband_pkg::RST_COLD: begin
        if (!cold_reset_cause) st_d = sideband_pkg::RST_RUN;
      end
      default: st_d = sideband_pkg::RST_RUN;
    endcase
  end

  wire in_reset_d = (st_d == sideband_pkg::RST_WARM_HOLD) || (st_d == sideband_pkg::RST_COLD);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= sideband_pkg::RST_COLD;
      wcnt_q <= '0;
      fabric_reset_out <= 1'h1;
      fabric_cold_reset_out <= 1'h1;
      warm_reset_req_out <= 1'h0;
    end else begin
      st_q <= st_d;
      wcnt_q <= (st_q == sideband_pkg::RST_WARM_REQ && !wtimeout) ? wcnt_q + 1'h1 : '0;
      fabric_reset_out <= in_reset_d;
      fabric_cold_reset_out <= (st_d == sideband_pkg::RST_COLD);
      warm_reset_req_out <= (st_d == sideband_pkg::RST_WARM_REQ);
    end
  end

  property p_irq_sync;
    @(posedge clk) disable iff (reset) 1'b1 ##3 (irq_to_gic == $past(irq_in, 3));
  endproperty
  a_irq_sync: assert property (p_irq_sync) else $error("irq not forwarded after sync");

  property p_cold_only;
    @(posedge clk) disable iff (reset) fabric_cold_reset_out |-> fabric_reset_out;
  endproperty
  a_cold_only: assert property (p_cold_only) else $error("cold reset without combined reset");

  property p_warm_req;
    @(posedge clk) disable iff (reset)
      (st_q == sideband_pkg::RST_RUN && warm_reset_cause && !cold_reset_cause) |=> warm_reset_req_out;
  endproperty
  a_warm_req: assert property (p_warm_req) else $error("warm request not raised");

  property p_dma;
    @(posedge clk) disable iff (reset) 1'b1 ##3 (dma_request_to_ctrl == $past(dma_request_in, 3));
  endproperty
  a_dma: assert property (p_dma) else $error("dma request lost");

  property p_reqs;
    @(posedge clk) disable iff (reset) 1'b1 ##3 (reset_request_to_mgr == $past(reset_request_in, 3));
  endproperty
  a_reqs: assert property (p_reqs) else $error("reset request lost");

  property p_wake;
    @(posedge clk) disable iff (reset) (wake_s2_q && core_in_wfe[0]) |=> core_wake[0];
  endproperty
  a_wake: assert property (p_wake) else $error("core not woken");

  property p_sev;
    @(posedge clk) disable iff (reset) (|core_send_event) |=> processor_event_bundle.wake_out;
  endproperty
  a_sev: assert property (p_sev) else $error("wake out missing");

  property p_flags;
    @(posedge clk) disable iff (reset)
      1'b1 |=> (processor_event_bundle.wait_event == $past(core_in_wfe)
                && processor_event_bundle.wait_irq == $past(core_in_wfi));
  endproperty
  a_flags: assert property (p_flags) else $error("standby flags wrong");

  property p_gp;
    @(posedge clk) disable iff (reset) 1'b1 ##3 (gp_to_processor == $past(gp_from_fabric, 3));
  endproperty
  a_gp: assert property (p_gp) else $error("gp path wrong");

  property p_trace;
    @(posedge clk) disable iff (reset)
      1'b1 ##3 (trace_msg_events == ($past(trace_event_inputs, 3) & ~$past(trace_event_inputs, 4))
                && trace_msg_valid == |($past(trace_event_inputs, 3) & ~$past(trace_event_inputs, 4)));
  endproperty
  a_trace: assert property (p_trace) else $error("trace message missing");

endmodule : processor_fabric_sideband

// file: test/fabric_model.sv
`timescale 1ns/1ps
`include "sideband_consts.svh"
module fabric_model (
  // clock and control
  input wire logic clk,
  input wire logic ack_en,
  // device side
  input wire logic warm_reset_req_out,
  output logic warm_reset_ack_in = 1'b0,
  output wire logic [`NUM_MEM_PORTS-1:0] memory_port_clock
);
  logic [1:0] dly_q = 2'h0;
  // one free-running clock per memory port, each with its own period
  for (genvar p = 0; p < `NUM_MEM_PORTS; p++) begin : g_clk
    logic ck = 1'b0;
    initial forever #(5 + 3 * p) ck = ~ck;
    assign memory_port_clock[p] = ck;
  end
  // acknowledge three cycles after the request is seen, withdrawn three cycles after it drops
  always @(posedge clk) begin
    dly_q <= {dly_q[0], warm_reset_req_out & ack_en};
    warm_reset_ack_in <= dly_q[1];
  end
endmodule : fabric_model

// file: test/tb_top.sv
`timescale 1ns/1ps
`include "sideband_consts.svh"
module tb_top;
  typedef struct packed {
    logic [63:0] irq; logic [7:0] dma; logic [2:0] rr; logic [31:0] gf, gp, tr;
    logic [1:0] wait_for_event_state, wait_for_interrupt_state, send_event_instruction; logic wk;
  } smp_t;
  logic clk, reset, cold_reset_cause, warm_reset_cause, wake_event_in, ack_en, cfg, t;
  logic fabric_reset_out, fabric_cold_reset_out, warm_reset_req_out, warm_reset_ack_in;
  logic trace_msg_valid, trace_port_clock_out, rnd_on, cmp_on;
  logic reset_want, cold_want, warm_want;
  logic [5:0] memory_port_clock, mem_port_clock_seen;
  logic [7:0] dma_request_in, dma_request_to_ctrl;
  logic [1:0] core_send_event, core_in_wfe, core_in_wfi, core_wake;
  logic [31:0] gp_from_fabric, gp_from_processor, gp_to_processor, gp_to_fabric;
  logic [31:0] trace_event_inputs, trace_msg_events;
  sideband_pkg::reset_req_t reset_request_in, reset_request_to_mgr;
  sideband_pkg::core_status_t processor_event_bundle;
  sideband_pkg::irq_pair_t irq_in, irq_to_gic;
  smp_t h[$];
  smp_t x;
  int n_mismatch, tests_run, cyc, i, n;
  processor_fabric_sideband uut (.clk, .reset, .memory_port_clock, .mem_port_clock_seen,
    .cold_reset_cause, .warm_reset_cause, .fabric_reset_out, .fabric_cold_reset_out,
    .warm_reset_req_out, .warm_reset_ack_in, .reset_request_in, .reset_request_to_mgr,
    .dma_request_in, .dma_request_to_ctrl, .wake_event_in, .core_send_event, .core_in_wfe,
    .core_in_wfi, .core_wake, .processor_event_bundle, .irq_in, .irq_to_gic,
    .gp_from_fabric, .gp_from_processor, .gp_to_processor, .gp_to_fabric,
    .trace_event_inputs, .trace_msg_valid, .trace_msg_events, .trace_port_clock_out);
  fabric_model partner (.clk, .ack_en, .warm_reset_req_out, .warm_reset_ack_in, .memory_port_clock);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  always @(posedge clk) begin
    reset <= reset_want;
    cold_reset_cause <= cold_want;
    warm_reset_cause <= warm_want;
    if (rnd_on) begin
      irq_in <= {$urandom(), $urandom()};
      dma_request_in <= 8'($urandom());
      reset_request_in <= 3'($urandom());
      gp_from_fabric <= $urandom();
      gp_from_processor <= $urandom();
      trace_event_inputs <= $urandom();
      core_in_wfe <= 2'($urandom());
      core_in_wfi <= 2'($urandom());
      core_send_event <= 2'($urandom());
      wake_event_in <= cfg & 1'($urandom());
    end
  end
  // reference pipeline: each result checked against the inputs it was caused by
  always @(negedge clk) if (cmp_on) begin
    h.push_front(smp_t'{irq_in, dma_request_in, reset_request_in, gp_from_fabric, gp_from_processor,
      trace_event_inputs, core_in_wfe, core_in_wfi, core_send_event, wake_event_in});
    if (h.size() > 6) void'(h.pop_back());
    if (h.size() == 6) begin
      chk(irq_to_gic, h[3].irq);
      chk(dma_request_to_ctrl, h[3].dma);
      chk(reset_request_to_mgr, h[3].rr);
      chk(gp_to_processor, h[3].gf);
      chk(gp_to_fabric, h[1].gp);
      chk(processor_event_bundle, {h[1].wait_for_event_state, h[1].wait_for_interrupt_state, |h[1].send_event_instruction});
      chk(trace_msg_events, h[3].tr & ~h[4].tr);
      chk(trace_msg_valid, |(h[3].tr & ~h[4].tr));
      chk(core_wake, {2{h[3].wk}} & h[1].wait_for_event_state);
    end
  end
  initial begin
    {reset, cold_reset_cause, warm_reset_cause, wake_event_in, cfg, rnd_on, cmp_on} = 7'h40;
    {reset_want, cold_want, warm_want} = 3'h4;
    {irq_in, dma_request_in, reset_request_in, gp_from_fabric, gp_from_processor} = '0;
    {trace_event_inputs, core_in_wfe, core_in_wfi, core_send_event} = '0;
    ack_en = 1'b1;
    {n_mismatch, tests_run, cyc} = '0;
    void'($urandom(69609));
    step(19);
    chk({fabric_reset_out, fabric_cold_reset_out, mem_port_clock_seen}, 8'hC0);
    reset_want = 1'b0;
    step(2);
    chk({fabric_reset_out, fabric_cold_reset_out}, 2'h0);
    cfg <= 1'b1;
    rnd_on <= 1'b1;
    cmp_on <= 1'b1;
    step(40);
    chk(mem_port_clock_seen, 6'h3F);
    t = trace_port_clock_out;
    n = 0;
    for (i = 0; i < 80; i++) begin
      step(1);
      if (trace_port_clock_out === 1'b1 && t === 1'b0) n++;
      t = trace_port_clock_out;
    end
    chk(n, 10);
    $display("test paths and clocks done");
    for (int m = 0; m < 2; m++) begin
      ack_en <= m == 0;
      warm_want = 1'b1;
      step(2);
      chk({warm_reset_req_out, fabric_cold_reset_out}, 2'h2);
      if (m == 1) step(4000);
      if (m == 1) chk(warm_reset_req_out, 1'b1);
      for (i = 0; i < 200 && warm_reset_req_out !== 1'b0; i++) step(1);
      chk({warm_reset_req_out, fabric_reset_out, fabric_cold_reset_out}, 3'h2);
      warm_want = 1'b0;
      step(3);
      chk(fabric_reset_out, 1'b0);
      // let the old acknowledge clear the synchroniser before the next request
      for (i = 0; i < 20 && warm_reset_ack_in !== 1'b0; i++) step(1);
      step(3);
      $display("test warm reset %0d done", m);
    end
    cold_want = 1'b1;
    step(3);
    chk({fabric_reset_out, fabric_cold_reset_out, warm_reset_req_out}, 3'h6);
    cold_want = 1'b0;
    step(3);
    chk({fabric_reset_out, fabric_cold_reset_out}, 2'h0);
    $display("test cold reset done");
    conclude();
  end
endmodule : tb_top
